// ### verilog/rtcp_pkg.sv
// Package for the real-time counter and periodic tick timer: register map, fields, constants
package rtcp_pkg;

  // Register byte addresses (one aligned 32-bit word each)
  localparam logic [7:0] ADDR_CTRL      = 8'h00;
  localparam logic [7:0] ADDR_STATUS    = 8'h04;
  localparam logic [7:0] ADDR_INTCTRL   = 8'h08;
  localparam logic [7:0] ADDR_INTFLAGS  = 8'h0c;
  localparam logic [7:0] ADDR_DBGCTRL   = 8'h14;
  localparam logic [7:0] ADDR_CLKSEL    = 8'h1c;
  localparam logic [7:0] ADDR_COUNT     = 8'h20;
  localparam logic [7:0] ADDR_PERIOD    = 8'h28;
  localparam logic [7:0] ADDR_COMPARE   = 8'h30;
  localparam logic [7:0] ADDR_TICKCTRL  = 8'h40;
  localparam logic [7:0] ADDR_TICKSTAT  = 8'h44;
  localparam logic [7:0] ADDR_TICKINTEN = 8'h48;
  localparam logic [7:0] ADDR_TICKFLAG  = 8'h4c;

  // Control and flag register field positions
  localparam int CTRL_EN_BIT      = 0;
  localparam int CTRL_PRESC_LSB   = 3;
  localparam int CTRL_STDBY_BIT   = 7;
  localparam int TICK_EN_BIT      = 0;
  localparam int TICK_PER_LSB     = 3;
  localparam int FLAG_OVF_BIT     = 0;
  localparam int FLAG_CMP_BIT     = 1;

  // Reset values
  localparam logic [15:0] RST_PERIOD  = 16'hffff;
  localparam logic [15:0] RST_COMPARE = 16'h0000;
  localparam logic [15:0] RST_COUNT   = 16'h0000;

  // Slow clock sources
  typedef enum logic [1:0] {
    RTCP_SRC_ULP     = 2'h0,
    RTCP_SRC_ULP_D32 = 2'h1,
    RTCP_SRC_XTAL    = 2'h2,
    RTCP_SRC_EXT     = 2'h3
  } rtcp_src_t;

  localparam logic [4:0] ULP_DIV_LAST = 5'h1f;  // Divide by 32
  localparam int SYNC_BUSY_CYCLES = 3;           // Unused; the busy flags stay set one cycle after a write
  localparam int SLOW_HZ = 32768;
  localparam int CORE_HZ = 200000000;

  // Counter event outputs grouped together
  typedef struct packed {
    logic ovf;
    logic cmp;
  } rtcp_evt_t;

endpackage

// ### verilog/rtcp_slow_tick.sv
// Slow clock source selection and edge detection into one-cycle core enables
`timescale 1ns/10ps
module rtcp_slow_tick (
  // Clock and reset
  input  wire logic       core_clk,
  input  wire logic       rstn,
  // Source pins, asynchronous to core_clk
  input  wire logic       ultra_low_power_osc,
  input  wire logic       watch_crystal_osc,
  input  wire logic       ext_clk_in,
  // Selection
  input  wire logic [1:0] src_sel,
  // One-cycle pulse per slow-clock rising edge
  output logic            slow_tick
);

  logic [2:0] s1_r;
  logic [2:0] s2_r;
  logic [2:0] s3_r;
  logic [4:0] ulp_div_r;
  logic [2:0] rise;
  logic       sel_tick;

  // Two-flop synchronisers; third stage only for edge detection
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      s1_r <= 3'h0;
      s2_r <= 3'h0;
      s3_r <= 3'h0;
    end else begin
      s1_r <= {ext_clk_in, watch_crystal_osc, ultra_low_power_osc};
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  assign rise = s2_r & ~s3_r;

  // Oscillator divided by 32, counted in rising edges
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      ulp_div_r <= 5'h00;
    end else if (rise[0]) begin
      ulp_div_r <= ulp_div_r + 5'h01;
    end
  end

  // Four-way source mux
  always_comb begin
    unique case (rtcp_pkg::rtcp_src_t'(src_sel))
      rtcp_pkg::RTCP_SRC_ULP:     sel_tick = rise[0];
      rtcp_pkg::RTCP_SRC_ULP_D32: sel_tick = rise[0] && (ulp_div_r == rtcp_pkg::ULP_DIV_LAST);
      rtcp_pkg::RTCP_SRC_XTAL:    sel_tick = rise[1];
      rtcp_pkg::RTCP_SRC_EXT:     sel_tick = rise[2];
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      slow_tick <= 1'b0;
    end else begin
      slow_tick <= sel_tick;
    end
  end

endmodule

// ### verilog/rtcp_top.sv
// Real-time counter with prescaler, compare and period, plus periodic tick timer
`timescale 1ns/10ps
// Behaviour
// - 16-bit counter compared to period and compare
// - Compare event on count after match
// - Overflow event on count after period match
// - Overflow returns counter to zero
// - Prescaler divides reference before the counter
// - Four selectable slow clock sources
// - Tick timer runs independent of counter enable
// - Tick interrupt 4..32768, events 64..8192
// - Tick timer uses same slow clock
// - Halt with processor under debugger
// - Debug run bit keeps block running
// - Wake from sleep, keep counting asleep
// - Enable bit starts and stops counting
// - Standby needs run bit; tick runs in standby
// - Interrupt held while enabled and flag set
module rtcp_top (
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        rstn,
  // Wishbone classic slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic [31:0]      wb_dat_o,
  output logic             wb_ack_o,
  // Slow clock sources (pins)
  input  wire logic        ultra_low_power_osc,
  input  wire logic        watch_crystal_osc,
  input  wire logic        ext_clk_in,
  // System state (pins)
  input  wire logic        debug_halt,
  input  wire logic        standby_sleep,
  // Interrupt requests and wake
  output logic             counter_irq,
  output logic             tick_irq,
  output logic             wake_req,
  // Events, one-cycle pulses
  output rtcp_pkg::rtcp_evt_t counter_evt,
  output logic [7:0]       tick_evt
);

  logic        slow_tick;
  logic [1:0]  halt_s_r;
  logic [1:0]  stdby_s_r;
  logic        ctrl_en_r;
  logic [3:0]  presc_sel_r;
  logic        stdby_run_r;
  logic [1:0]  intctrl_r;
  logic [1:0]  flags_r;
  logic        dbg_run_r;
  logic [1:0]  clksel_r;
  logic [15:0] count_r;
  logic [15:0] period_r;
  logic [15:0] compare_r;
  logic [14:0] presc_cnt_r;
  logic        tick_en_r;
  logic [3:0]  tick_per_r;
  logic        tick_ie_r;
  logic        tick_flag_r;
  logic [14:0] tick_cnt_r;
  logic [3:0]  busy_r;
  logic        tick_busy_r;
  logic        bus_req;
  logic        wr;
  logic        running;
  logic        cnt_step;
  logic        tick_step;
  logic [14:0] tick_nxt;
  logic [1:0]  evt_set;
  logic        tick_set;

  // Selected source, synchronised and turned into enable pulses
  // Switching source while counting may shorten one slow period
  rtcp_slow_tick u_slow (
    .core_clk            (core_clk),
    .rstn                (rstn),
    .ultra_low_power_osc (ultra_low_power_osc),
    .watch_crystal_osc   (watch_crystal_osc),
    .ext_clk_in          (ext_clk_in),
    .src_sel             (clksel_r),
    .slow_tick           (slow_tick)
  );

  // Power of two mask test: divider hits when low bits all ones
  // Shared by prescaler, tick interrupt and tick events so the periods agree
  function automatic logic pow2_hit(input logic [14:0] cnt, input logic [3:0] sel);
    logic [14:0] mask;
    mask = 15'((16'h0001 << sel) - 16'h0001);
    return (cnt & mask) == mask;
  endfunction

  // Pin level synchronisers
  // Only the second stage is read, the first may be metastable
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      halt_s_r  <= 2'h0;
      stdby_s_r <= 2'h0;
    end else begin
      halt_s_r  <= {halt_s_r[0], debug_halt};
      stdby_s_r <= {stdby_s_r[0], standby_sleep};
    end
  end

  // Stopped under debug halt unless debug run set; standby needs its run bit
  assign running = (!halt_s_r[1] || dbg_run_r)
                 && (!stdby_s_r[1] || stdby_run_r);

  // A held request is answered every other cycle: ack blocks a take in its own cycle
  assign bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wr      = bus_req && wb_we_i && wb_sel_i[0];

  // Prescaler counts slow ticks; counter steps at the chosen power of two
  // Disabling clears it so that every enable starts a full prescaled period
  always_ff @(posedge core_clk) begin
    if (!rstn || !ctrl_en_r) begin
      presc_cnt_r <= 15'h0000;
    end else if (slow_tick && running) begin
      presc_cnt_r <= presc_cnt_r + 15'h0001;
    end
  end

  assign cnt_step = ctrl_en_r && running && slow_tick
                  && pow2_hit(presc_cnt_r, presc_sel_r);

  // Counter with wrap at period; a software write wins over a step
  // Writing COUNT in a step cycle drops that step, never the written value
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      count_r <= rtcp_pkg::RST_COUNT;
    end else if (wr && wb_adr_i == rtcp_pkg::ADDR_COUNT) begin
      count_r <= wb_dat_i[15:0];
    end else if (cnt_step) begin
      count_r <= (count_r == period_r) ? 16'h0000 : count_r + 16'h0001;
    end
  end

  // Events fire at the count that leaves the equal value, so overflow and
  // the wrap to zero are one and the same step
  assign evt_set = {cnt_step && (count_r == compare_r),
                    cnt_step && (count_r == period_r)};

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      counter_evt <= '0;
    end else begin
      counter_evt.cmp <= evt_set[1];
      counter_evt.ovf <= evt_set[0];
    end
  end

  // Tick timer free-runs on the same slow clock, independent of counter enable
  // It ignores standby on purpose; only its enable bit or a debugger halt can stop it
  assign tick_step = tick_en_r && slow_tick && (!halt_s_r[1] || dbg_run_r);
  assign tick_nxt  = tick_cnt_r + 15'h0001;

  always_ff @(posedge core_clk) begin
    if (!rstn || !tick_en_r) begin
      tick_cnt_r <= 15'h0000;
    end else if (tick_step) begin
      tick_cnt_r <= tick_nxt;
    end
  end

  // Interrupt period 4..32768 selected by code 1..14; code 0 is off
  // Code 15 would ask for 65536, beyond the 15-bit tick counter, so it is off too
  assign tick_set = tick_step && (tick_per_r != 4'h0) && (tick_per_r != 4'hf)
                  && pow2_hit(tick_cnt_r, 4'(tick_per_r + 4'h1));

  // Event k fires every 8192 >> k slow periods
  // A mask of 13 - k ones gives a period of 2 to the power 13 - k
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      tick_evt <= 8'h00;
    end else begin
      for (int k = 0; k < 8; k++) begin
        tick_evt[k] <= tick_step && pow2_hit(tick_cnt_r, 4'(13 - k));
      end
    end
  end

  // Sticky flags, set beats a same-cycle clear by write-one
  // so an event that lands on the clearing write is never lost
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      flags_r     <= 2'h0;
      tick_flag_r <= 1'b0;
    end else begin
      if (wr && wb_adr_i == rtcp_pkg::ADDR_INTFLAGS) begin
        flags_r <= (flags_r & ~wb_dat_i[1:0]) | evt_set;
      end else begin
        flags_r <= flags_r | evt_set;
      end
      if (wr && wb_adr_i == rtcp_pkg::ADDR_TICKFLAG) begin
        tick_flag_r <= (tick_flag_r & ~wb_dat_i[0]) | tick_set;
      end else begin
        tick_flag_r <= tick_flag_r | tick_set;
      end
    end
  end

  // Requests held while enabled and flagged; they also serve as wake
  // Registered so the outputs come straight from flip-flops, one cycle after the flag
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      counter_irq <= 1'b0;
      tick_irq    <= 1'b0;
      wake_req    <= 1'b0;
    end else begin
      counter_irq <= |(flags_r & intctrl_r);
      tick_irq    <= tick_flag_r && tick_ie_r;
      wake_req    <= |(flags_r & intctrl_r) || (tick_flag_r && tick_ie_r);
    end
  end

  // Software registers; writes take effect at the ack edge
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      ctrl_en_r   <= 1'b0;
      presc_sel_r <= 4'h0;
      stdby_run_r <= 1'b0;
      intctrl_r   <= 2'h0;
      dbg_run_r   <= 1'b0;
      clksel_r    <= 2'h0;
      period_r    <= rtcp_pkg::RST_PERIOD;
      compare_r   <= rtcp_pkg::RST_COMPARE;
      tick_en_r   <= 1'b0;
      tick_per_r  <= 4'h0;
      tick_ie_r   <= 1'b0;
    end else if (wr) begin
      unique case (wb_adr_i)
        rtcp_pkg::ADDR_CTRL: begin
          ctrl_en_r   <= wb_dat_i[rtcp_pkg::CTRL_EN_BIT];
          presc_sel_r <= wb_dat_i[rtcp_pkg::CTRL_PRESC_LSB +: 4];
          stdby_run_r <= wb_dat_i[rtcp_pkg::CTRL_STDBY_BIT];
        end
        rtcp_pkg::ADDR_INTCTRL:   intctrl_r  <= wb_dat_i[1:0];
        rtcp_pkg::ADDR_DBGCTRL:   dbg_run_r  <= wb_dat_i[0];
        rtcp_pkg::ADDR_CLKSEL:    clksel_r   <= wb_dat_i[1:0];
        rtcp_pkg::ADDR_PERIOD:    period_r   <= wb_dat_i[15:0];
        rtcp_pkg::ADDR_COMPARE:   compare_r  <= wb_dat_i[15:0];
        rtcp_pkg::ADDR_TICKINTEN: tick_ie_r  <= wb_dat_i[0];
        rtcp_pkg::ADDR_TICKCTRL: begin
          tick_en_r  <= wb_dat_i[rtcp_pkg::TICK_EN_BIT];
          tick_per_r <= wb_dat_i[rtcp_pkg::TICK_PER_LSB +: 4];
        end
        default: ;
      endcase
    end
  end

  // Busy flags: set on write, cleared after a short settle (informative only)
  // Registers here settle in the core clock, so software never waits longer
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      busy_r      <= 4'h0;
      tick_busy_r <= 1'b0;
    end else begin
      busy_r[0]   <= wr && wb_adr_i == rtcp_pkg::ADDR_CTRL;
      busy_r[1]   <= wr && wb_adr_i == rtcp_pkg::ADDR_COUNT;
      busy_r[2]   <= wr && wb_adr_i == rtcp_pkg::ADDR_PERIOD;
      busy_r[3]   <= wr && wb_adr_i == rtcp_pkg::ADDR_COMPARE;
      tick_busy_r <= wr && wb_adr_i == rtcp_pkg::ADDR_TICKCTRL;
    end
  end

  // Ack one cycle after the request; unmapped reads return zero
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= bus_req;
      wb_dat_o <= 32'h0000_0000;
      if (bus_req && !wb_we_i) begin
        unique case (wb_adr_i)
          rtcp_pkg::ADDR_CTRL:
            wb_dat_o <= {24'h0, stdby_run_r, presc_sel_r, 2'h0, ctrl_en_r};
          rtcp_pkg::ADDR_STATUS:    wb_dat_o <= {28'h0, busy_r[3], busy_r[2], busy_r[1], busy_r[0]};
          rtcp_pkg::ADDR_INTCTRL:   wb_dat_o <= {30'h0, intctrl_r};
          rtcp_pkg::ADDR_INTFLAGS:  wb_dat_o <= {30'h0, flags_r};
          rtcp_pkg::ADDR_DBGCTRL:   wb_dat_o <= {31'h0, dbg_run_r};
          rtcp_pkg::ADDR_CLKSEL:    wb_dat_o <= {30'h0, clksel_r};
          rtcp_pkg::ADDR_COUNT:     wb_dat_o <= {16'h0, count_r};
          rtcp_pkg::ADDR_PERIOD:    wb_dat_o <= {16'h0, period_r};
          rtcp_pkg::ADDR_COMPARE:   wb_dat_o <= {16'h0, compare_r};
          rtcp_pkg::ADDR_TICKCTRL:  wb_dat_o <= {25'h0, tick_per_r, 2'h0, tick_en_r};
          rtcp_pkg::ADDR_TICKSTAT:  wb_dat_o <= {31'h0, tick_busy_r};
          rtcp_pkg::ADDR_TICKINTEN: wb_dat_o <= {31'h0, tick_ie_r};
          rtcp_pkg::ADDR_TICKFLAG:  wb_dat_o <= {31'h0, tick_flag_r};
          default:                  wb_dat_o <= 32'h0000_0000;
        endcase
      end
    end
  end

endmodule

// ### sim/rtcp_top_properties.sv
// Checker of bus handshake, event pulses and interrupt levels of the counter block
`timescale 1ns/10ps
module rtcp_top_properties (
  // Clock and reset
  input wire logic                core_clk,
  input wire logic                rstn,
  // Register bus
  input wire logic                wb_cyc_i,
  input wire logic                wb_stb_i,
  input wire logic                wb_ack_o,
  input wire logic [31:0]         wb_dat_o,
  // Requests and events
  input wire logic                counter_irq,
  input wire logic                tick_irq,
  input wire logic                wake_req,
  input wire rtcp_pkg::rtcp_evt_t counter_evt,
  input wire logic [7:0]          tick_evt
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);
  // Request that is taken at this edge
  sequence bus_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  // Answer of exactly one cycle
  sequence ack_pulse;
    wb_ack_o ##1 !wb_ack_o;
  endsequence
  ack_answer_a: assert property (bus_req |=> ack_pulse)
    else $error("bus answer missing or too long");
  ack_cause_a: assert property (wb_ack_o |-> $past(wb_cyc_i) && $past(wb_stb_i))
    else $error("bus answer without request");
  dat_idle_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
    else $error("read data outside answer");
  // Slow steps are at least four core cycles apart, so pulses cannot merge
  ovf_pulse_a: assert property (counter_evt.ovf |=> !counter_evt.ovf [*3])
    else $error("overflow pulse too long");
  cmp_pulse_a: assert property (counter_evt.cmp |=> !counter_evt.cmp [*3])
    else $error("compare pulse too long");
  tick_pulse_a: assert property (tick_evt[7] |=> !tick_evt[7])
    else $error("tick event pulse too long");
  // Only a bus write may drop a pending request
  irq_hold_a: assert property (counter_irq && !wb_cyc_i && !$past(wb_cyc_i) |=> counter_irq)
    else $error("counter request dropped by itself");
  tick_hold_a: assert property (tick_irq && !wb_cyc_i && !$past(wb_cyc_i) |=> tick_irq)
    else $error("tick request dropped by itself");
  wake_or_a: assert property (counter_irq || tick_irq |-> ##[0:2] wake_req)
    else $error("wake missing for pending request");
endmodule

bind rtcp_top rtcp_top_properties u_props (
  .core_clk(core_clk), .rstn(rstn), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_ack_o(wb_ack_o), .wb_dat_o(wb_dat_o), .counter_irq(counter_irq),
  .tick_irq(tick_irq), .wake_req(wake_req), .counter_evt(counter_evt), .tick_evt(tick_evt)
);

// ### sim/testbench.sv
// Self-checking bench for the real-time counter and periodic tick timer
`timescale 1ns/10ps
module testbench;
  logic                core_clk;
  logic                rstn  = 1'b0;
  logic                cyc   = 1'b0;
  logic                stb   = 1'b0;
  logic                we    = 1'b0;
  logic                dhalt = 1'b0;
  logic                stby  = 1'b0;
  logic                slow  = 1'b0;
  logic [2:0]          pm    = 3'h0;
  logic [3:0]          sel   = 4'h0;
  logic [7:0]          adr   = 8'h00;
  logic [31:0]         dat_i = 32'h0;
  logic [31:0]         rnd   = 32'd50634;
  logic [31:0]         dat_o;
  logic [7:0]          tevt;
  logic                ack, cirq, tirq, wake;
  rtcp_pkg::rtcp_evt_t cevt;
  int                  n_mismatch = 0;
  int                  n_tests = 0;
  int                  scnt = 0;
  int                  dv = 0;
  int                  t0, t1;
  logic [31:0]         expq[$];
  string               nmq[$];

  // Only the pin picked in pm toggles, so a wrong source pick stalls the counter
  rtcp_top DUT (
    .core_clk(core_clk), .rstn(rstn), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat_i), .wb_dat_o(dat_o), .wb_ack_o(ack),
    .ultra_low_power_osc(slow & pm[0]), .watch_crystal_osc(slow & pm[1]),
    .ext_clk_in(slow & pm[2]), .debug_halt(dhalt), .standby_sleep(stby),
    .counter_irq(cirq), .tick_irq(tirq), .wake_req(wake), .counter_evt(cevt),
    .tick_evt(tevt)
  );

  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end

  // Slow reference of 16 core cycles; scnt counts its rising edges
  always @(posedge core_clk) begin
    dv <= (dv == 7) ? 0 : dv + 1;
    if (dv == 7) begin
      slow <= ~slow;
      if (!slow) scnt <= scnt + 1;
    end
  end

  function automatic logic [31:0] xs(input logic [31:0] x);
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction

  function automatic logic sig(input int i);
    case (i)
      0: return cevt.ovf;
      1: return cevt.cmp;
      2: return tirq;
      3: return tevt[7];
      default: return tevt[6];
    endcase
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string nm);
    n_tests++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // One classic cycle; a read notes its expected data for the monitor
  task automatic wb(input logic w, input logic [3:0] s, input logic [7:0] a,
                    input logic [31:0] d, input string nm);
    int n;
    if (!w) begin
      expq.push_back(d);
      nmq.push_back(nm);
    end
    cyc   <= 1'b1;
    stb   <= 1'b1;
    we    <= w;
    sel   <= s;
    adr   <= a;
    dat_i <= d;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (ack !== 1'b1 && n < 100);
    if (n >= 100) check(32'h0, 32'h1, "ack wait");
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge core_clk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    wb(1'b1, 4'h1, a, d, "");
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e, input string nm);
    wb(1'b0, 4'h1, a, e, nm);
  endtask

  // Read data is only valid in the answer cycle
  always @(posedge core_clk) begin
    if (ack === 1'b1 && we === 1'b0 && expq.size() > 0) check(dat_o, expq.pop_front(), nmq.pop_front());
  end

  task automatic waitp(input int i, output int t);
    int n;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (sig(i) !== 1'b1 && n < 9000);
    if (n >= 9000) check(32'h0, 32'h1, "event wait");
    t = scnt;
  endtask

  task automatic gap(input int i, input int e, input string nm);
    waitp(i, t0);
    waitp(i, t1);
    check(t1 - t0, e, nm);
  endtask

  // Counts overflow pulses over a window that would hold about fifteen
  task automatic quiet(input string nm);
    int p;
    p = 0;
    repeat (1000) begin
      @(posedge core_clk);
      if (cevt.ovf === 1'b1) p++;
    end
    check(p, 0, nm);
  endtask

  task automatic summarize;
    if (n_mismatch == 0 && n_tests > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  initial begin
    #400000;
    n_mismatch++;
    summarize();
  end

  initial begin
    repeat (20) @(posedge core_clk);
    rstn <= 1'b1;
    rd(rtcp_pkg::ADDR_COUNT, {16'h0, rtcp_pkg::RST_COUNT}, "count rst");
    rd(rtcp_pkg::ADDR_PERIOD, {16'h0, rtcp_pkg::RST_PERIOD}, "period rst");
    rd(rtcp_pkg::ADDR_COMPARE, {16'h0, rtcp_pkg::RST_COMPARE}, "cmp rst");
    rd(8'hfc, 32'h0, "unmapped");
    rnd = xs(rnd);
    wr(rtcp_pkg::ADDR_COMPARE, {16'h0, rnd[15:0]});
    wb(1'b1, 4'h0, rtcp_pkg::ADDR_COMPARE, ~rnd, "");
    rd(rtcp_pkg::ADDR_COMPARE, {16'h0, rnd[15:0]}, "cmp rw");
    wr(rtcp_pkg::ADDR_COMPARE, 32'h1);
    wr(rtcp_pkg::ADDR_PERIOD, 32'h3);
    wr(rtcp_pkg::ADDR_INTCTRL, 32'h3);
    rd(rtcp_pkg::ADDR_STATUS, 32'h0, "busy clear");
    // Every source, with the wrap of a period of three
    for (int k = 0; k < 4; k++) begin
      pm <= (k < 2) ? 3'h1 : ((k == 2) ? 3'h2 : 3'h4);
      wr(rtcp_pkg::ADDR_CLKSEL, k);
      wr(rtcp_pkg::ADDR_CTRL, 32'h1);
      gap(0, (k == 1) ? 128 : 4, "ovf gap");
      rd(rtcp_pkg::ADDR_COUNT, 32'h0, "ovf wrap");
      if (k == 2) gap(1, 4, "cmp gap");
      if (k == 2) rd(rtcp_pkg::ADDR_COUNT, 32'h2, "cmp step");
      wr(rtcp_pkg::ADDR_CTRL, 32'h0);
    end
    for (int p = 1; p < 4; p++) begin
      wr(rtcp_pkg::ADDR_CTRL, 32'h0);
      wr(rtcp_pkg::ADDR_CTRL, (p << 3) | 1);
      gap(0, 4 << p, "presc gap");
    end
    wr(rtcp_pkg::ADDR_CTRL, 32'h0);
    check(cirq, 1'b1, "irq set");
    check(wake, 1'b1, "wake");
    rd(rtcp_pkg::ADDR_INTFLAGS, 32'h3, "flags set");
    wr(rtcp_pkg::ADDR_INTCTRL, 32'h0);
    check(cirq, 1'b0, "irq masked");
    wr(rtcp_pkg::ADDR_INTCTRL, 32'h1);
    check(cirq, 1'b1, "irq unmasked");
    wr(rtcp_pkg::ADDR_INTFLAGS, 32'h3);
    check(cirq, 1'b0, "irq cleared");
    rd(rtcp_pkg::ADDR_INTFLAGS, 32'h0, "flags clr");
    // Debug halt, then standby: stopped until the keep-running bit is set
    for (int m = 0; m < 2; m++) begin
      if (m == 0) dhalt <= 1'b1;
      else stby <= 1'b1;
      repeat (3) @(posedge core_clk);
      wr(rtcp_pkg::ADDR_CTRL, 32'h1);
      quiet("stopped");
      if (m == 0) wr(rtcp_pkg::ADDR_DBGCTRL, 32'h1);
      else wr(rtcp_pkg::ADDR_CTRL, 32'h81);
      gap(0, 4, "keep run");
      dhalt <= 1'b0;
      stby <= 1'b0;
      wr(rtcp_pkg::ADDR_DBGCTRL, 32'h0);
    end
    wr(rtcp_pkg::ADDR_CTRL, 32'h0);
    wr(rtcp_pkg::ADDR_COUNT, 32'h2);
    repeat (200) @(posedge core_clk);
    rd(rtcp_pkg::ADDR_COUNT, 32'h2, "count held");
    // Tick timer with the counter off, in standby
    stby <= 1'b1;
    wr(rtcp_pkg::ADDR_TICKINTEN, 32'h1);
    rd(rtcp_pkg::ADDR_TICKSTAT, 32'h0, "tick busy clear");
    for (int c = 1; c < 3; c++) begin
      wr(rtcp_pkg::ADDR_TICKCTRL, (c << 3) | 1);
      wr(rtcp_pkg::ADDR_TICKFLAG, 32'h1);
      waitp(2, t0);
      wr(rtcp_pkg::ADDR_TICKFLAG, 32'h1);
      waitp(2, t1);
      check(t1 - t0, 2 << c, "tick gap");
    end
    gap(3, 64, "tick evt gap");
    gap(4, 128, "tick evt6 gap");
    stby <= 1'b0;
    summarize();
  end
endmodule
